/* fupc_pkg.sv */
// Purpose: Constants and carriers for the flash user program controller
// Assumes: 100 MHz aclk, AXI4-Lite register access, 8-bit registers in 32-bit words
// Notes:   Register fields sit in the low byte of each word
//
// Overview of operation
// R1 - Erase whole sectors, program single bytes
// R2 - No user mode on sub-system clock
// R3 - Any pending interrupt request halts user mode
// R4 - Masked pending request still halts it
// R5 - Control bit 0 launches erase or lock
// R6 - Byte read/program never use start bit
// R7 - Software waits for erase before sector access
// R8 - Erase status bit is read-only
// R9 - Interrupt during erase abandons the erase
// R10 - Status zero on success, one on failure
// R11 - Reset clears key register to zero
// R12 - Only key A5 enables user mode
// R13 - Memory is 128 sectors of 128 bytes
// R14 - Sector address in high and low registers
// R15 - Low seven bits of low register ignored
// R16 - Software reloads sector before other-sector writes
// R17 - Control register usable only in user mode
// R18 - Read protection not settable here
// R19 - Software allows 10 ms for erase
// R20 - Bytes programmed singly after sector erase
// R21 - Program only in mode and loaded sector
package fupc_pkg;

  // ******************************************************************
  // Register map (byte addresses)
  // ******************************************************************
  localparam logic [7:0] FUPC_OFS_KEY    = 8'h00;
  localparam logic [7:0] FUPC_OFS_CTRL   = 8'h04;
  localparam logic [7:0] FUPC_OFS_SEC_HI = 8'h08;
  localparam logic [7:0] FUPC_OFS_SEC_LO = 8'h0c;
  localparam logic [7:0] FUPC_OFS_STATE  = 8'h10;

  // ******************************************************************
  // Field layout and values
  // ******************************************************************
  localparam int         FUPC_CTRL_START_BIT  = 0;
  localparam int         FUPC_CTRL_FAIL_BIT   = 3;
  localparam int         FUPC_CTRL_MODE_LSB   = 4;
  localparam logic [3:0] FUPC_MODE_ERASE      = 4'ha;
  localparam logic [3:0] FUPC_MODE_PROGRAM    = 4'h5;
  localparam logic [3:0] FUPC_MODE_HARD_LOCK  = 4'h6;
  localparam logic [7:0] FUPC_KEY_ENABLE      = 8'ha5;
  localparam logic [7:0] FUPC_KEY_RESET       = 8'h00;
  localparam logic [7:0] FUPC_ERASED_BYTE     = 8'hff;
  localparam logic [1:0] FUPC_RESP_OKAY       = 2'b00;
  localparam logic [1:0] FUPC_RESP_SLVERR     = 2'b10;

  // ******************************************************************
  // Geometry and timing
  // ******************************************************************
  localparam int FUPC_SECTORS         = 128;
  localparam int FUPC_SECTOR_BYTES    = 128;
  localparam int FUPC_CLK_MHZ         = 100;
  localparam int FUPC_ERASE_TIME_US   = 10000;
  localparam int FUPC_ERASE_CYCLES    = FUPC_ERASE_TIME_US * FUPC_CLK_MHZ;

  // Load-instruction request from the CPU core
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fupc_ld_req_t;

  // Controller sequencing, one-hot
  typedef enum logic [1:0] {
    FUPC_ST_IDLE  = 2'b01,
    FUPC_ST_ERASE = 2'b10
  } fupc_state_t;

endpackage : fupc_pkg

/* fupc_ctrl.sv */
// Purpose: Flash user program controller with embedded flash array
// Assumes: Inputs synchronous to aclk; CPU holds ld_req while ld_valid and !ld_ready
// Notes:   Erase fills bytes with ones; programming can only clear bits
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module fupc_ctrl #(
  parameter int SECTORS      = fupc_pkg::FUPC_SECTORS,
  parameter int SECTOR_BYTES = fupc_pkg::FUPC_SECTOR_BYTES,
  parameter int ERASE_CYCLES = fupc_pkg::FUPC_ERASE_CYCLES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Program-memory load instruction port
  input  wire logic                  ld_valid,
  output logic                       ld_ready,
  input  wire fupc_pkg::fupc_ld_req_t ld_req,
  output logic                       ld_rvalid,
  output logic [7:0]                 ld_rdata,
  // CPU environment
  input  wire logic                  irq_pending,
  input  wire logic                  sub_clock_active,
  output logic                       user_mode,
  output logic                       erase_busy,
  output logic                       hard_locked
);

  localparam int MEM_BYTES = SECTORS * SECTOR_BYTES;
  localparam int IDX_W     = $clog2(MEM_BYTES);

  // ******************************************************************
  // Behaviour summary
  // ******************************************************************
  // Key word gates user mode; any other value shuts it
  // Control word: mode nibble, read-only fail flag, start in bit 0
  // Sector number: high byte plus bit 7 of the low byte
  // State word: mode, fail, busy and lock, always readable
  // Unmapped words answer a slave error and change nothing
  //
  // Erase timeline from the start write
  //   First sector-size cycles: one byte per cycle set to ones
  //   Remaining cycles: busy only, stands in for cell recovery
  //   Last cycle: busy drops with the fail flag clear
  // Interrupt or slow clock ends an erase at once, fail set;
  // software must check the flag and retry
  //
  // Load port
  //   Reads always served, answer one cycle after the take
  //   Writes only clear bits, dropped outside the loaded sector
  //
  // Limitations
  //   Whole array stalls during erase, not only one sector
  //   Lock is sticky; only reset clears it
  //   No control path for read protection

  // ******************************************************************
  // Elaboration checks
  // ******************************************************************
  // Sector split across high byte and low bit 7 fixes the geometry
  if (SECTOR_BYTES != 128) begin : g_bad_sector
    $error("SECTOR_BYTES must be 128");
  end
  if (SECTORS < 2 || SECTORS > 512 || (SECTORS & (SECTORS - 1)) != 0) begin : g_bad_count
    $error("SECTORS must be a power of two up to 512");
  end
  // Erase must last at least one write per sector byte
  if (ERASE_CYCLES < SECTOR_BYTES || ERASE_CYCLES > 32'h7fffffff) begin : g_bad_erase
    $error("ERASE_CYCLES must cover one pass over a sector");
  end

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    // Write phases, held until both halves are in
    logic [7:0]            aw_addr;
    logic                  aw_held;
    logic [7:0]            w_data;
    logic                  w_strb0;
    logic                  w_held;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    // Software-visible registers
    logic [7:0]            key;
    logic [3:0]            mode;
    logic                  fail;
    logic                  locked;
    logic [7:0]            sec_hi;
    logic                  sec_lo7;
    // Erase sequencer
    fupc_pkg::fupc_state_t state;
    logic [31:0]           cnt;
    logic [8:0]            erase_sec;
    // Load port answer
    logic                  ld_rvalid;
    logic [7:0]            ld_rdata;
  } fupc_regs_t;

  fupc_regs_t       s_q;
  fupc_regs_t       s_d;
  logic [7:0]       mem_q [0:MEM_BYTES-1];
  logic             mem_we;
  logic [IDX_W-1:0] mem_waddr;
  logic [7:0]       mem_wdata;

  // ******************************************************************
  // Mode decode
  // ******************************************************************
  logic       mode_en;
  logic       busy;
  logic       wr_go;
  logic       ar_go;
  logic       ld_go;
  logic [8:0] ld_sector;
  logic [8:0] cur_sector;
  logic [7:0] ctrl_view;

  // Key match gated by main clock
  assign mode_en    = (s_q.key == fupc_pkg::FUPC_KEY_ENABLE) && !sub_clock_active; // R12 R2
  // Busy decodes state flops only, keeping ld_ready short
  assign busy       = (s_q.state == fupc_pkg::FUPC_ST_ERASE);
  assign ld_sector  = ld_req.addr[15:7];
  assign cur_sector = {s_q.sec_hi, s_q.sec_lo7};                        // R14 R15
  assign wr_go      = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign ar_go      = s_axi_arvalid && !s_q.rvalid;
  assign ld_go      = ld_valid && ld_ready;

  // Start bit reads back as running; fail bit cannot be written
  assign ctrl_view = {s_q.mode, s_q.fail, 2'b00, busy};                 // R8

  // ******************************************************************
  // Handshake and outputs
  // ******************************************************************
  // Whole array stalls during erase; simpler than per-sector tracking
  assign ld_ready      = !busy;                                         // R7
  assign s_axi_awready = !s_q.aw_held;
  assign s_axi_wready  = !s_q.w_held;
  assign s_axi_arready = !s_q.rvalid;
  // Responses come straight from flops
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign ld_rvalid     = s_q.ld_rvalid;
  assign ld_rdata      = s_q.ld_rdata;
  // Status for the CPU environment
  assign user_mode     = mode_en;
  assign erase_busy    = busy;
  assign hard_locked   = s_q.locked;

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    logic [7:0] wd;
    logic       hit;
    logic [3:0] wmode;
    wd        = s_q.w_data;
    hit       = 1'b0;
    wmode     = wd[fupc_pkg::FUPC_CTRL_MODE_LSB +: 4];
    s_d       = s_q;
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = fupc_pkg::FUPC_ERASED_BYTE;

    // Address and data phases taken in either order
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_addr = s_axi_awaddr;
      s_d.aw_held = 1'b1;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_data  = s_axi_wdata[7:0];
      s_d.w_strb0 = s_axi_wstrb[0];
      s_d.w_held  = 1'b1;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Register write, once both phases are held
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = fupc_pkg::FUPC_RESP_OKAY;
      hit         = s_q.w_strb0;
      // Only lane 0 carries register bits; a cleared strobe
      // still answers OKAY, as a harmless no-op
      // Address decoded from the held phase, not the bus
      case (s_q.aw_addr)
        fupc_pkg::FUPC_OFS_KEY: begin
          if (hit) begin
            s_d.key = wd;                                               // R12
          end
        end

        fupc_pkg::FUPC_OFS_CTRL: begin
          // Ignored outside user mode and while an erase runs
          if (hit && mode_en && !busy) begin                            // R17
            s_d.mode = wmode;
            if (wd[fupc_pkg::FUPC_CTRL_START_BIT]) begin                // R5
              if (wmode == fupc_pkg::FUPC_MODE_ERASE && !s_q.locked) begin
                s_d.state     = fupc_pkg::FUPC_ST_ERASE;                // R1 R13
                s_d.cnt       = '0;
                s_d.fail      = 1'b0;
                s_d.erase_sec = cur_sector;
              end else if (wmode == fupc_pkg::FUPC_MODE_HARD_LOCK) begin
                s_d.locked = 1'b1;
              end
            end
          end
        end
        fupc_pkg::FUPC_OFS_SEC_HI: begin
          if (hit) begin
            s_d.sec_hi = wd;                                            // R14
          end
        end
        fupc_pkg::FUPC_OFS_SEC_LO: begin
          if (hit) begin
            s_d.sec_lo7 = wd[7];                                        // R15
          end
        end

        // State word is read-only; writes are dropped
        fupc_pkg::FUPC_OFS_STATE: begin
          s_d.bresp = fupc_pkg::FUPC_RESP_OKAY;
        end

        // Unmapped write: flagged, nothing stored
        default: begin
          s_d.bresp = fupc_pkg::FUPC_RESP_SLVERR;
        end
      endcase
    end

    // Register read
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = '0;
      s_d.rresp  = fupc_pkg::FUPC_RESP_OKAY;
      // Decoded from the bus; arready already gates the take
      case (s_axi_araddr)
        // Key reads back so software can confirm the unlock
        fupc_pkg::FUPC_OFS_KEY: begin
          s_d.rdata[7:0] = s_q.key;
        end

        // Control word reads zero outside user mode
        fupc_pkg::FUPC_OFS_CTRL: begin
          if (mode_en) begin
            s_d.rdata[7:0] = ctrl_view;                                 // R17 R10
          end
        end

        // Sector words read back as stored
        fupc_pkg::FUPC_OFS_SEC_HI: begin
          s_d.rdata[7:0] = s_q.sec_hi;
        end
        fupc_pkg::FUPC_OFS_SEC_LO: begin
          s_d.rdata[7:0] = {s_q.sec_lo7, 7'h00};                        // R15
        end

        fupc_pkg::FUPC_OFS_STATE: begin
          // Always visible, so software can poll after dropping the key
          s_d.rdata[3:0] = {s_q.locked, busy, s_q.fail, mode_en};
        end

        // Unmapped read: error with zero data
        default: begin
          s_d.rresp = fupc_pkg::FUPC_RESP_SLVERR;
        end
      endcase
    end

    // Erase sequencing; the key may be dropped once started
    case (s_q.state)
      // Counter parked at zero so every start runs full length
      fupc_pkg::FUPC_ST_IDLE: begin
        s_d.cnt = '0;
      end

      // Abort checked first: an interrupt beats progress
      fupc_pkg::FUPC_ST_ERASE: begin
        if (irq_pending || sub_clock_active) begin                      // R3 R4 R9 R2
          s_d.state = fupc_pkg::FUPC_ST_IDLE;
          s_d.fail  = 1'b1;                                             // R10
        end else begin
          if (s_q.cnt < 32'(SECTOR_BYTES)) begin
            mem_we    = 1'b1;                                           // R1
            mem_waddr = IDX_W'({s_q.erase_sec, s_q.cnt[6:0]});
          end
          // Last counted cycle closes the erase cleanly
          if (s_q.cnt == 32'(ERASE_CYCLES - 1)) begin
            s_d.state = fupc_pkg::FUPC_ST_IDLE;
            s_d.fail  = 1'b0;                                           // R10
          end else begin
            s_d.cnt = s_q.cnt + 32'd1;
          end
        end
      end

      // Illegal code after an upset: fall back to idle
      default: begin
        s_d.state = fupc_pkg::FUPC_ST_IDLE;
      end
    endcase

    // A write never answers; the CPU re-reads to confirm it
    // Load instruction: reads always, writes under guard, no start bit
    s_d.ld_rvalid = 1'b0;
    if (ld_go) begin                                                    // R6
      if (!ld_req.write) begin
        s_d.ld_rvalid = 1'b1;
        s_d.ld_rdata  = mem_q[IDX_W'(ld_req.addr)];
      end else if (mode_en && !s_q.locked && !irq_pending
                   && s_q.mode == fupc_pkg::FUPC_MODE_PROGRAM
                   && ld_sector == cur_sector) begin                    // R21 R3 R4
        mem_we    = 1'b1;
        mem_waddr = IDX_W'(ld_req.addr);
        // Cells only go from one to zero, so erase must come first
        mem_wdata = mem_q[IDX_W'(ld_req.addr)] & ld_req.wdata;          // R20
      end
    end

    // Read protection has no control path in this mode
    s_d.locked = s_d.locked;                                            // R18
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.key       <= fupc_pkg::FUPC_KEY_RESET;                        // R11
      s_q.state     <= fupc_pkg::FUPC_ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Flash array, not cleared by reset like real cells
  // One write port: erase and load writes never meet
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem_q[mem_waddr] <= mem_wdata;
    end
  end

endmodule : fupc_ctrl

/* fupc_checker.sv */
// Purpose: Temporal checks on the flash user program controller ports
// Assumes: One aclk domain, aresetn synchronous and active low
// Notes:   Bound into fupc_ctrl below; sees port values only
`timescale 1ns/1ps
module fupc_checker #(
  parameter int ERASE_CYCLES = 200
) (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   ld_valid,
  input wire logic                   ld_ready,
  input wire fupc_pkg::fupc_ld_req_t ld_req,
  input wire logic                   ld_rvalid,
  input wire logic                   irq_pending,
  input wire logic                   sub_clock_active,
  input wire logic                   user_mode,
  input wire logic                   erase_busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int busy_q;
  // Cycles spent busy; a stuck erase would otherwise go unseen
  always_ff @(posedge aclk) busy_q <= (erase_busy && aresetn) ? busy_q + 1 : 0;
  // ******************************************************************
  // Assertions
  // ******************************************************************
  sequence s_rd_taken;
    ld_valid && ld_ready && !ld_req.write;
  endsequence
  property p_key_reset; $rose(aresetn) |-> !user_mode; endproperty
  property p_sub_clk; sub_clock_active |-> !user_mode; endproperty
  property p_irq_abort; erase_busy && irq_pending |=> !erase_busy; endproperty
  property p_sub_abort; erase_busy && sub_clock_active |=> !erase_busy; endproperty
  property p_rd_answer; s_rd_taken |=> ld_rvalid; endproperty
  property p_rd_only; ld_rvalid |-> $past(ld_valid && ld_ready && !ld_req.write); endproperty
  property p_busy_stall; erase_busy && $past(erase_busy) |-> !ld_rvalid; endproperty
  property p_start_mode; $rose(erase_busy) |-> $past(user_mode); endproperty
  property p_erase_len; erase_busy |-> busy_q <= ERASE_CYCLES; endproperty
  a_key_reset: assert property (p_key_reset) else $error("mode on after reset");
  a_sub_clk: assert property (p_sub_clk) else $error("mode on sub clock");
  a_irq_abort: assert property (p_irq_abort) else $error("erase kept on irq");
  a_sub_abort: assert property (p_sub_abort) else $error("erase kept on sub clock");
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_only: assert property (p_rd_only) else $error("stray read pulse");
  a_busy_stall: assert property (p_busy_stall) else $error("load taken in erase");
  a_start_mode: assert property (p_start_mode) else $error("erase outside mode");
  a_erase_len: assert property (p_erase_len) else $error("erase too long");
endmodule : fupc_checker

bind fupc_ctrl fupc_checker #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.aclk, .aresetn,
  .ld_valid, .ld_ready, .ld_req, .ld_rvalid, .irq_pending, .sub_clock_active,
  .user_mode, .erase_busy);

/* fupc_cpu_model.sv */
// Purpose: CPU core issuing program-memory load instructions
// Assumes: Requests change right after a rising edge, held until taken
// Notes:   A released request bus shows the inverse of its last value
`timescale 1ns/1ps
module fupc_cpu_model (
  input  wire logic              aclk,
  input  wire logic              ld_ready,
  input  wire logic [7:0]        ld_rdata,
  output logic                   ld_valid,
  output fupc_pkg::fupc_ld_req_t ld_req
);
  // Idle bus at time zero
  initial begin
    ld_valid = 1'b0;
    ld_req = '0;
  end
  // One load; waits out an erase, then lets an edge pass before returning
  task automatic issue(input logic w, input logic [15:0] a, input logic [7:0] d);
    ld_req <= '{write: w, addr: a, wdata: d};
    ld_valid <= 1'b1;
    do @(posedge aclk); while (!ld_ready);
    ld_valid <= 1'b0;
    ld_req <= ~ld_req;
    @(posedge aclk);
  endtask : issue
  // Read byte lands one edge after the take
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    issue(1'b0, a, 8'h00);
    d = ld_rdata;
  endtask : rd
endmodule : fupc_cpu_model

/* fupc_ctrl_tb.sv */
// Purpose: Self-checking bench for the flash user program controller
// Assumes: ERASE_CYCLES shortened to 200 so full erases stay cheap
// Notes:   AXI master and CPU model wait for answers under a cycle limit
`timescale 1ns/1ps
module fupc_ctrl_tb;
  localparam int         EC   = 200;
  localparam logic [7:0] KEY  = fupc_pkg::FUPC_OFS_KEY;
  localparam logic [7:0] CTRL = fupc_pkg::FUPC_OFS_CTRL;
  localparam logic [7:0] SECH = fupc_pkg::FUPC_OFS_SEC_HI;
  localparam logic [7:0] SECL = fupc_pkg::FUPC_OFS_SEC_LO;
  localparam logic [7:0] STAT = fupc_pkg::FUPC_OFS_STATE;
  localparam logic [1:0] OK   = fupc_pkg::FUPC_RESP_OKAY;
  localparam logic [1:0] ERR  = fupc_pkg::FUPC_RESP_SLVERR;
  logic        aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic        irq_pending, sub_clock_active, ld_valid, ld_ready, erase_busy, hard_locked;
  logic        user_mode, ld_rvalid;
  logic [3:0]  ws;
  logic [7:0]  awa, ara, ld_rdata;
  logic [31:0] wd, rdata;
  logic [1:0]  bresp, rresp;
  int          mismatches, n_compared, cycles;
  fupc_pkg::fupc_ld_req_t ld_req;

  fupc_ctrl #(.ERASE_CYCLES(EC)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .ld_valid(ld_valid),
    .ld_ready(ld_ready), .ld_req(ld_req), .ld_rvalid(ld_rvalid), .ld_rdata(ld_rdata),
    .irq_pending(irq_pending), .sub_clock_active(sub_clock_active), .user_mode(user_mode),
    .erase_busy(erase_busy), .hard_locked(hard_locked));
  fupc_cpu_model cpu (.aclk(aclk), .ld_ready(ld_ready), .ld_rdata(ld_rdata),
    .ld_valid(ld_valid), .ld_req(ld_req));

  // 100 MHz clock
  always #5 aclk = ~aclk;
  // Hang guard; a full run needs well under 3000 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict;
    end
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // AXI write; each channel released at its own handshake
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic [1:0] got;
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv);
    got = bresp;
    br <= 1'b0;
    @(posedge aclk);
    check({32'h0, got}, {32'h0, r});
  endtask : axw
  // AXI read; upper data bits must read zero
  task automatic axr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    check({rresp, rdata}, {r, 24'h000000, d});
    @(posedge aclk);
  endtask : axr
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset;
    axr(KEY, 8'h00, OK);
    axw(CTRL, 8'ha1, OK);
    check(34'(erase_busy), 34'h0);
    ws <= 4'he;
    axw(KEY, 8'ha5, OK);
    ws <= 4'hf;
    check(34'(user_mode), 34'h0);
    axw(KEY, 8'h5a, OK);
    check(34'(user_mode), 34'h0);
    axr(STAT, 8'h00, OK);
    axr(CTRL, 8'h00, OK);
    axw(8'h14, 8'h00, ERR);
    axr(8'h14, 8'h00, ERR);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_erase;
    logic [7:0] b;
    axw(KEY, 8'ha5, OK);
    check(34'(user_mode), 34'h1);
    axw(SECH, 8'h00, OK);
    axw(SECL, 8'hff, OK);
    axr(SECL, 8'h80, OK);
    axr(SECH, 8'h00, OK);
    axw(CTRL, 8'ha1, OK);
    axr(STAT, 8'h05, OK);
    repeat (EC / 2) @(posedge aclk);
    check(34'(erase_busy), 34'h1);
    cpu.rd(16'h0085, b);
    check(34'(b), 34'hff);
    check(34'(ld_rvalid), 34'h1);
    repeat (EC) if (erase_busy) @(posedge aclk);
    axr(CTRL, 8'ha0, OK);
    axw(CTRL, 8'h50, OK);
    cpu.issue(1'b1, 16'h0085, 8'h3c);
    cpu.rd(16'h0085, b);
    check(34'(b), 34'h3c);
    irq_pending <= 1'b1;
    cpu.issue(1'b1, 16'h0087, 8'h00);
    irq_pending <= 1'b0;
    cpu.rd(16'h0087, b);
    check(34'(b), 34'hff);
    cpu.rd(16'h00ff, b);
    check(34'(b), 34'hff);
    axw(SECL, 8'h00, OK);
    cpu.issue(1'b1, 16'h0086, 8'h00);
    cpu.rd(16'h0086, b);
    check(34'(b), 34'hff);
    $display("t_erase done");
  endtask : t_erase
  task automatic t_abort;
    axw(CTRL, 8'ha1, OK);
    repeat (3) @(posedge aclk);
    irq_pending <= 1'b1;
    repeat (2) @(posedge aclk);
    check(34'(erase_busy), 34'h0);
    irq_pending <= 1'b0;
    axr(CTRL, 8'ha8, OK);
    axw(CTRL, 8'h50, OK);
    axr(CTRL, 8'h58, OK);
    axw(CTRL, 8'ha1, OK);
    sub_clock_active <= 1'b1;
    repeat (2) @(posedge aclk);
    check(34'(erase_busy), 34'h0);
    axr(STAT, 8'h02, OK);
    sub_clock_active <= 1'b0;
    $display("t_abort done");
  endtask : t_abort
  task automatic t_lock;
    axw(CTRL, 8'h61, OK);
    check(34'(hard_locked), 34'h1);
    axw(CTRL, 8'ha1, OK);
    check(34'(erase_busy), 34'h0);
    axr(STAT, 8'h0b, OK);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(STAT, 8'h00, OK);
    $display("t_lock done");
  endtask : t_lock

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Reset for three cycles, then the scenarios in order
  initial begin
    {aclk, aresetn, awv, wv, br, arv, rr, irq_pending, sub_clock_active} = '0;
    {awa, ara, wd} = '0;
    ws = 4'hf;
    {mismatches, n_compared, cycles} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_erase;
    t_abort;
    t_lock;
    print_verdict;
  end
endmodule : fupc_ctrl_tb
